//--- src/ssc_sample_sequencer_control.sv
// Sampling sequencer, mode control and register file
`timescale 1ns/1ps
`include "ssc_defines.svh"
module ssc_sample_sequencer_control #(
  parameter int ADC_W = 14,
  parameter int SUM_W = 20,
  parameter int AVG_W = 27
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             sync_reset,
  input  wire logic [7:0]       addr,
  input  wire logic [15:0]      wr_data,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic      [15:0]      rd_data,
  input  wire logic             general_pin_zero,
  input  wire logic             general_pin_one,
  input  wire logic [ADC_W-1:0] adc_value,
  output logic                  led_drive,
  output logic                  adc_strobe,
  output logic                  slot_a_active,
  output logic                  slot_b_active,
  output logic      [15:0]      channel_connect,
  output ssc_pkg::ssc_mode_t    mode,
  output logic      [1:0]       data_ready
);
  import ssc_pkg::*;

  if (ADC_W < 1 || ADC_W > SUM_W || SUM_W + 7 > AVG_W || AVG_W > 32) begin : g_bad_widths
    $error("ssc: unsupported widths");
  end

  // ***********************************
  // Register file
  // ***********************************
  ssc_mode_t   mode_reg;
  logic [1:0]  slot_en_reg;
  logic [15:0] rate_reg;
  logic [15:0] route_reg;
  logic [15:0] avg_reg;
  logic [7:0]  pulses_reg [2];
  logic [15:0] slot_ctl_reg;
  logic [15:0] clk_cfg_reg;
  logic [15:0] pin_cfg_reg;
  logic [AVG_W-1:0] data_reg [2];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg      <= SSC_MODE_STANDBY;
      slot_en_reg   <= 2'h3;
      rate_reg      <= `SSC_RATE_RESET;
      route_reg     <= 16'h0000;
      avg_reg       <= 16'h0000;
      pulses_reg[0] <= 8'h01;
      pulses_reg[1] <= 8'h01;
      slot_ctl_reg  <= 16'h0000;
      clk_cfg_reg   <= `SSC_CLK_CFG_RESET;
      pin_cfg_reg   <= 16'h0000;
    end else if (sync_reset) begin
      mode_reg <= SSC_MODE_STANDBY;
    end else if (wr_en) begin
      case (addr)
        `SSC_REG_MODE:     mode_reg      <= ssc_mode_t'(wr_data[1:0]);
        `SSC_REG_SLOT_EN:  slot_en_reg   <= wr_data[1:0];
        `SSC_REG_RATE:     rate_reg      <= wr_data;
        `SSC_REG_ROUTE:    route_reg     <= wr_data;
        `SSC_REG_AVG:      avg_reg       <= wr_data;
        `SSC_REG_PULSE_A:  pulses_reg[0] <= wr_data[15:8];
        `SSC_REG_PULSE_B:  pulses_reg[1] <= wr_data[15:8];
        `SSC_REG_SLOT_CTL: slot_ctl_reg  <= wr_data;
        `SSC_REG_CLK_CFG:  clk_cfg_reg   <= wr_data;
        `SSC_REG_PIN_CFG:  pin_cfg_reg   <= wr_data;
        default: begin
        end
      endcase
    end
  end
  assign mode = mode_reg;

  // ***********************************
  // Sample clock and start of cycle
  // ***********************************
  ssc_state_t  state_reg;
  logic        tick;
  logic        normal;
  logic [15:0] per_cnt_reg;
  logic [15:0] sleep_cnt_reg;
  logic        pin_prev_reg;
  logic        ext_pending_reg;
  logic        ext_wait_reg;
  logic [1:0]  sync_sel;
  logic        sync_on;
  logic        sync_pin;
  logic        sync_rise;
  logic        ext_due;
  logic        int_due;
  logic        start;

  ssc_sample_clock u_clock (
    .clk        (clk),
    .rstn       (rstn),
    .tune       (clk_cfg_reg[5:0]),
    .src_sel    (clk_cfg_reg[8:7]),
    .ext_clk_in (general_pin_one),
    .tick       (tick)
  );

  assign normal   = (mode_reg == SSC_MODE_NORMAL);
  assign sync_sel = pin_cfg_reg[3:2];
  assign sync_on  = (sync_sel == `SSC_SYNC_PIN_ZERO && pin_cfg_reg[1]) ||
                    (sync_sel == `SSC_SYNC_PIN_ONE && pin_cfg_reg[5]);
  assign sync_pin  = (sync_sel == `SSC_SYNC_PIN_ONE) ? general_pin_one : general_pin_zero;
  assign sync_rise = sync_on && normal && sync_pin && !pin_prev_reg;
  assign ext_due   = ext_pending_reg && ext_wait_reg && tick;
  assign int_due   = !sync_on && tick && (per_cnt_reg + 16'h0001 >= rate_reg);
  assign start     = normal && (state_reg == SSC_SLEEP) && (ext_due || int_due) &&
                     (sleep_cnt_reg >= `SSC_MIN_SLEEP_TICKS) && (slot_en_reg != 2'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= sync_pin;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_pending_reg <= 1'b0;
      ext_wait_reg    <= 1'b0;
    end else if (sync_reset || !normal || ext_due) begin
      ext_pending_reg <= 1'b0;
      ext_wait_reg    <= 1'b0;
    end else if (sync_rise && !ext_pending_reg) begin
      ext_pending_reg <= 1'b1;
      ext_wait_reg    <= 1'b0;
    end else if (ext_pending_reg && tick) begin
      ext_wait_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      per_cnt_reg   <= 16'h0000;
      sleep_cnt_reg <= 16'h0000;
    end else if (!normal || start) begin
      per_cnt_reg   <= 16'h0000;
      sleep_cnt_reg <= 16'h0000;
    end else if (tick) begin
      if (per_cnt_reg != 16'hFFFF) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
      if (state_reg == SSC_SLEEP && sleep_cnt_reg != 16'hFFFF) begin
        sleep_cnt_reg <= sleep_cnt_reg + 16'h0001;
      end
    end
  end

  // ***********************************
  // Slot sequencer
  // ***********************************
  logic [11:0] timer_reg;
  logic [7:0]  left_reg;
  logic        setup_reg;
  logic        cur_b;
  logic        timer_done;
  logic        conv_now;
  logic        proc_done;

  assign cur_b      = (state_reg == SSC_B_PULSE) || (state_reg == SSC_B_PROC);
  function automatic logic [7:0] eff_pulses(input logic [7:0] p);
    eff_pulses = (p == 8'h00) ? 8'h01 : p;
  endfunction
  assign timer_done = (timer_reg == 12'h000);
  assign conv_now   = timer_done && !setup_reg && (state_reg == SSC_A_PULSE || state_reg == SSC_B_PULSE);
  assign proc_done  = timer_done && (state_reg == SSC_A_PROC || state_reg == SSC_B_PROC);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SSC_SLEEP;
      timer_reg <= 12'h000;
      left_reg  <= 8'h00;
      setup_reg <= 1'b0;
    end else if (sync_reset || !normal) begin
      state_reg <= SSC_SLEEP;
      timer_reg <= 12'h000;
      setup_reg <= 1'b0;
    end else begin
      case (state_reg)
        SSC_SLEEP: begin
          if (start) begin
            state_reg <= slot_en_reg[0] ? SSC_A_PULSE : SSC_B_PULSE;
            timer_reg <= 12'(`SSC_SETUP_CYC - 1);
            left_reg  <= eff_pulses(pulses_reg[!slot_en_reg[0]]);
            setup_reg <= 1'b1;
          end
        end
        SSC_A_PULSE, SSC_B_PULSE: begin
          if (!timer_done) begin
            timer_reg <= timer_reg - 12'h001;
          end else if (setup_reg) begin
            setup_reg <= 1'b0;
            timer_reg <= 12'(`SSC_PULSE_CYC - 1);
          end else if (left_reg <= 8'h01) begin
            state_reg <= cur_b ? SSC_B_PROC : SSC_A_PROC;
            timer_reg <= cur_b ? 12'(`SSC_PROC_B_CYC - 1) : 12'(`SSC_PROC_A_CYC - 1);
            left_reg  <= 8'h00;
          end else begin
            left_reg  <= left_reg - 8'h01;
            timer_reg <= 12'(`SSC_PULSE_CYC - 1);
          end
        end
        SSC_A_PROC: begin
          if (!timer_done) begin
            timer_reg <= timer_reg - 12'h001;
          end else if (slot_en_reg[1]) begin
            state_reg <= SSC_B_PULSE;
            timer_reg <= 12'(`SSC_SETUP_CYC - 1);
            left_reg  <= eff_pulses(pulses_reg[1]);
            setup_reg <= 1'b1;
          end else begin
            state_reg <= SSC_SLEEP;
          end
        end
        SSC_B_PROC: begin
          if (!timer_done) begin
            timer_reg <= timer_reg - 12'h001;
          end else begin
            state_reg <= SSC_SLEEP;
          end
        end
        default: state_reg <= SSC_SLEEP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_drive     <= 1'b0;
      adc_strobe    <= 1'b0;
      slot_a_active <= 1'b0;
      slot_b_active <= 1'b0;
    end else begin
      led_drive     <= normal && !sync_reset && !setup_reg &&
                       (state_reg == SSC_A_PULSE || state_reg == SSC_B_PULSE) && !timer_done;
      adc_strobe    <= normal && !sync_reset && conv_now;
      slot_a_active <= (state_reg == SSC_A_PULSE) || (state_reg == SSC_A_PROC);
      slot_b_active <= (state_reg == SSC_B_PULSE) || (state_reg == SSC_B_PROC);
    end
  end

  ssc_slot_router u_router (
    .clk      (clk),
    .rstn     (rstn),
    .sel_code (slot_b_active ? route_reg[11:8] : (slot_a_active ? route_reg[7:4] : `SSC_SEL_FLOAT)),
    .connect  (channel_connect)
  );

  // ***********************************
  // Pulse sum and intersample averaging
  // ***********************************
  logic [SUM_W-1:0] sum_reg;
  logic [SUM_W:0]   sum_wide;

  function automatic logic [7:0] avg_count(input logic [2:0] exp2);
    avg_count = 8'(9'h001 << exp2);
  endfunction

  assign sum_wide = {1'b0, sum_reg} + (SUM_W + 1)'(adc_value);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sum_reg      <= '0;
    end else if (state_reg == SSC_SLEEP || (timer_done && setup_reg)) begin
      sum_reg <= '0;
    end else if (adc_strobe) begin
      sum_reg <= sum_wide[SUM_W] ? '1 : sum_wide[SUM_W-1:0];
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_slot
      logic [AVG_W-1:0] acc_reg;
      logic [7:0]       cnt_reg;
      logic [7:0]       n_avg;
      logic             fire;
      assign n_avg = avg_count(avg_reg[s*4 +: 3]);
      assign fire  = proc_done && (cur_b == 1'(s)) && normal && !sync_reset;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          acc_reg       <= '0;
          cnt_reg       <= 8'h00;
          data_reg[s]   <= '0;
          data_ready[s] <= 1'b0;
        end else begin
          data_ready[s] <= 1'b0;
          if (fire) begin
            if (cnt_reg + 8'h01 >= n_avg) begin
              data_reg[s]   <= acc_reg + AVG_W'(sum_reg);
              acc_reg       <= '0;
              cnt_reg       <= 8'h00;
              data_ready[s] <= 1'b1;
            end else begin
              acc_reg <= acc_reg + AVG_W'(sum_reg);
              cnt_reg <= cnt_reg + 8'h01;
            end
          end
        end
      end
      property p_avg_every_n;
        @(posedge clk) disable iff (!rstn) data_ready[s] |-> ($past(cnt_reg) + 8'h01 >= $past(n_avg));
      endproperty
      a_avg_every_n: assert property (p_avg_every_n) else $error("output updated before N samples");
    end
  endgenerate

  // ***********************************
  // Register read port
  // ***********************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      case (addr)
        `SSC_REG_MODE:      rd_data <= {14'h0000, mode_reg};
        `SSC_REG_SLOT_EN:   rd_data <= {14'h0000, slot_en_reg};
        `SSC_REG_RATE:      rd_data <= rate_reg;
        `SSC_REG_ROUTE:     rd_data <= route_reg;
        `SSC_REG_AVG:       rd_data <= avg_reg;
        `SSC_REG_PULSE_A:   rd_data <= {pulses_reg[0], 8'h00};
        `SSC_REG_PULSE_B:   rd_data <= {pulses_reg[1], 8'h00};
        `SSC_REG_SLOT_CTL:  rd_data <= slot_ctl_reg;
        `SSC_REG_CLK_CFG:   rd_data <= clk_cfg_reg;
        `SSC_REG_PIN_CFG:   rd_data <= pin_cfg_reg;
        `SSC_REG_DATA_A_LO: rd_data <= 16'(data_reg[0]);
        `SSC_REG_DATA_A_HI: rd_data <= 16'(32'(data_reg[0]) >> 16);
        `SSC_REG_DATA_B_LO: rd_data <= 16'(data_reg[1]);
        `SSC_REG_DATA_B_HI: rd_data <= 16'(32'(data_reg[1]) >> 16);
        `SSC_REG_STATUS:    rd_data <= {9'h000, ext_pending_reg, 1'b0, state_reg};
        default:            rd_data <= 16'h0000;
      endcase
    end
  end

  // ***********************************
  // Assertions
  // ***********************************
  sequence s_leave_a;
    (state_reg == SSC_A_PROC) ##1 (state_reg == SSC_B_PULSE);
  endsequence
  property p_idle_off_normal;
    @(posedge clk) disable iff (!rstn) !normal |=> (state_reg == SSC_SLEEP) && !led_drive;
  endproperty
  a_idle_off_normal: assert property (p_idle_off_normal) else $error("activity outside normal mode");
  property p_sync_reset;
    @(posedge clk) disable iff (!rstn)
      sync_reset |=> (mode_reg == SSC_MODE_STANDBY) && (state_reg == SSC_SLEEP) && !ext_pending_reg;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync reset did not stop sequencer");
  property p_run_needs_normal;
    @(posedge clk) disable iff (!rstn) (state_reg != SSC_SLEEP) |-> ($past(mode_reg) == SSC_MODE_NORMAL);
  endproperty
  a_run_needs_normal: assert property (p_run_needs_normal) else $error("cycle running out of normal");
  property p_slot_a_unused;
    @(posedge clk) disable iff (!rstn) ($past(!slot_en_reg[0]) && $past(state_reg) == SSC_SLEEP)
      |-> (state_reg != SSC_A_PULSE);
  endproperty
  a_slot_a_unused: assert property (p_slot_a_unused) else $error("disabled slot A ran");
  property p_b_after_a;
    @(posedge clk) disable iff (!rstn) s_leave_a |-> $past(slot_en_reg[1]);
  endproperty
  a_b_after_a: assert property (p_b_after_a) else $error("slot B ran while disabled");
  property p_sync_arm;
    @(posedge clk) disable iff (!rstn) (sync_rise && !ext_pending_reg && !sync_reset) |=> ext_pending_reg;
  endproperty
  a_sync_arm: assert property (p_sync_arm) else $error("sync edge not taken");
  property p_sync_wait;
    @(posedge clk) disable iff (!rstn) (sync_on && ext_pending_reg && !ext_wait_reg && tick) |-> !start;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync start before second sample tick");
  property p_route_b;
    @(posedge clk) disable iff (!rstn)
      (slot_b_active && route_reg[11:8] == `SSC_SEL_SUM) ##1 $stable(route_reg) |-> channel_connect == `SSC_CONN_SUM;
  endproperty
  a_route_b: assert property (p_route_b) else $error("slot B routing not applied");
  property p_led_in_pulse;
    @(posedge clk) disable iff (!rstn) led_drive |-> $past(state_reg == SSC_A_PULSE || state_reg == SSC_B_PULSE);
  endproperty
  a_led_in_pulse: assert property (p_led_in_pulse) else $error("LED driven outside pulse phase");
endmodule // ssc_sample_sequencer_control

//--- src/ssc_defines.svh
// Constants of the sample sequencer control block
// Behaviour
// - Slot B input select is routing bits 11:8, used only in slot B
// - Slot A input select is routing bits 7:4, used only in slot A
// - Select code zero floats all inputs; codes besides 0, 1, 5 are reserved
// - Code one sums photodiodes onto channel one, externals onto channel two
// - Code five maps ext1, ext2, small and large photodiode to channels one to four
// - Sample rate register sets the period; tuning bits 5:0 trim the sample clock
// - State machine and sample timing advance on the 32 kHz sample clock; code: only period and start use it, slot phases count clk
// - An unused slot adds neither pulse nor processing time to the period
// - With external sync, a rising edge on the chosen pin starts the next cycle
// - After a sync edge wait one to two sample clocks, then start normally
// - Clock source code two replaces the internal clock by pin one
// - Mode field: zero standby, one program, two normal sampling
// - Standby collects no data and keeps every register
// - Mode is standby right after power-up
// - Normal mode drives LED pulses and acquires data every period
// - A sample sums 1 to 255 pulse conversions
// - Averaging over N, a power of two 1 to 128, updates outputs every N
// - Each period runs slot A then slot B, each with its own datapath
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_REG_MODE       8'h10
`define SSC_REG_SLOT_EN    8'h11
`define SSC_REG_RATE       8'h12
`define SSC_REG_ROUTE      8'h14
`define SSC_REG_AVG        8'h15
`define SSC_REG_PULSE_A    8'h31
`define SSC_REG_PULSE_B    8'h36
`define SSC_REG_SLOT_CTL   8'h38
`define SSC_REG_CLK_CFG    8'h4B
`define SSC_REG_PIN_CFG    8'h4F
`define SSC_REG_DATA_A_LO  8'h64
`define SSC_REG_DATA_A_HI  8'h65
`define SSC_REG_DATA_B_LO  8'h66
`define SSC_REG_DATA_B_HI  8'h67
`define SSC_REG_STATUS     8'h70
`define SSC_RATE_RESET     16'h0020
`define SSC_CLK_CFG_RESET  16'h0000
`define SSC_CLK_SRC_EXT    2'h2
`define SSC_SYNC_PIN_ZERO  2'h1
`define SSC_SYNC_PIN_ONE   2'h2
`define SSC_PIN1_IN_ON     2'h1
`define SSC_SEL_FLOAT      4'h0
`define SSC_SEL_SUM        4'h1
`define SSC_SEL_DIRECT     4'h5
`define SSC_CONN_SUM       16'h00C3
`define SSC_CONN_DIRECT    16'h2184
`define SSC_CLK_HZ         40000000
`define SSC_CLK_MHZ        40
`define SSC_SAMPLE_HZ      32768
`define SSC_DIV_BASE       (`SSC_CLK_HZ / `SSC_SAMPLE_HZ)
`define SSC_TUNE_CENTER    32
`define SSC_SETUP_US       25
`define SSC_PULSE_US       19
`define SSC_PROC_A_US      68
`define SSC_PROC_B_US      20
`define SSC_SETUP_CYC      (`SSC_SETUP_US * `SSC_CLK_MHZ)
`define SSC_PULSE_CYC      (`SSC_PULSE_US * `SSC_CLK_MHZ)
`define SSC_PROC_A_CYC     (`SSC_PROC_A_US * `SSC_CLK_MHZ)
`define SSC_PROC_B_CYC     (`SSC_PROC_B_US * `SSC_CLK_MHZ)
`define SSC_MIN_SLEEP_TICKS 16'h0001
`endif

//--- src/ssc_pkg.sv
// Types of the sample sequencer control block
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_MODE_STANDBY = 2'h0,
    SSC_MODE_PROGRAM = 2'h1,
    SSC_MODE_NORMAL  = 2'h2
  } ssc_mode_t;
  typedef enum logic [4:0] {
    SSC_SLEEP   = 5'h01,
    SSC_A_PULSE = 5'h02,
    SSC_A_PROC  = 5'h04,
    SSC_B_PULSE = 5'h08,
    SSC_B_PROC  = 5'h10
  } ssc_state_t;
endpackage

//--- src/ssc_sample_clock.sv
// Sample clock tick from trimmed divider or external pin
`timescale 1ns/1ps
`include "ssc_defines.svh"
module ssc_sample_clock (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [5:0] tune,
  input  wire logic [1:0] src_sel,
  input  wire logic       ext_clk_in,
  output logic            tick
);
  import ssc_pkg::*;
  logic [10:0] div_reg;
  logic        ext_q_reg;
  logic [10:0] period;
  logic        use_ext;
  logic        ext_rise;
  assign period   = 11'(`SSC_DIV_BASE - `SSC_TUNE_CENTER) + {5'h00, tune};
  assign use_ext  = (src_sel == `SSC_CLK_SRC_EXT);
  assign ext_rise = ext_clk_in & ~ext_q_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= ext_clk_in;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 11'h000;
      tick    <= 1'b0;
    end else if (use_ext) begin
      div_reg <= 11'h000;
      tick    <= ext_rise;
    end else if (div_reg >= period - 11'h001) begin
      div_reg <= 11'h000;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 11'h001;
      tick    <= 1'b0;
    end
  end
  property p_ext_tick;
    @(posedge clk) disable iff (!rstn)
      (use_ext && $past(use_ext) && tick) |-> $past(ext_rise);
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("tick without pin edge on external clock");
endmodule // ssc_sample_clock

//--- src/ssc_slot_router.sv
// Input to channel switch matrix for the active slot
`timescale 1ns/1ps
`include "ssc_defines.svh"
module ssc_slot_router (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  sel_code,
  output logic      [15:0] connect
);
  import ssc_pkg::*;
  function automatic logic [15:0] route_of(input logic [3:0] code);
    case (code)
      `SSC_SEL_SUM:    route_of = `SSC_CONN_SUM;
      `SSC_SEL_DIRECT: route_of = `SSC_CONN_DIRECT;
      default:         route_of = 16'h0000;
    endcase
  endfunction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      connect <= 16'h0000;
    end else begin
      connect <= route_of(sel_code);
    end
  end
  property p_float;
    @(posedge clk) disable iff (!rstn) (sel_code == `SSC_SEL_FLOAT) |=> (connect == 16'h0000);
  endproperty
  a_float: assert property (p_float) else $error("inputs not floating for code zero");
  property p_sum;
    @(posedge clk) disable iff (!rstn) (sel_code == `SSC_SEL_SUM) |=> (connect == `SSC_CONN_SUM);
  endproperty
  a_sum: assert property (p_sum) else $error("summing routing wrong");
  property p_direct;
    @(posedge clk) disable iff (!rstn) (sel_code == `SSC_SEL_DIRECT) |=> (connect == `SSC_CONN_DIRECT);
  endproperty
  a_direct: assert property (p_direct) else $error("direct routing wrong");
endmodule // ssc_slot_router

//--- tb/ssc_far_model.sv
// Far side model: sync pins, external sample clock, conversion source
`timescale 1ns/1ps
module ssc_far_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [13:0] level,
  input  wire logic        fire,
  input  wire logic        run,
  output logic             pin_zero,
  output logic             pin_one,
  output logic      [13:0] adc_value
);
  logic [6:0]  cnt_reg;
  logic [10:0] div_reg;
  logic        ck_reg;
  assign pin_zero  = cnt_reg != 7'h00;
  assign pin_one   = ck_reg;
  assign adc_value = level;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_reg <= 7'h00;
    else if (fire) cnt_reg <= 7'h40;
    else if (cnt_reg != 7'h00) cnt_reg <= cnt_reg - 7'h01;
  end
  // Clock stands low while not running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 11'h000;
      ck_reg  <= 1'b0;
    end else if (!run) begin
      div_reg <= 11'h000;
      ck_reg  <= 1'b0;
    end else if (div_reg == 11'h261) begin
      div_reg <= 11'h000;
      ck_reg  <= ~ck_reg;
    end else div_reg <= div_reg + 11'h001;
  end
endmodule // ssc_far_model

//--- tb/ssc_sample_sequencer_control_tb.sv
// Self-checking bench of the sample sequencer control block
`timescale 1ns/1ps
module ssc_sample_sequencer_control_tb;
  import ssc_pkg::*;
  logic        clk = 0, rstn = 0, sync_reset = 0, wr_en = 0, rd_en = 0, fire = 0, run = 0;
  logic        rd_seen = 0, a_q = 0, b_q = 0, p0, p1, led, stb, sa, sb;
  logic [7:0]  addr = 0;
  logic [15:0] wr_data = 0, rd_data, conn;
  logic [13:0] level = 0, adc;
  logic [1:0]  dr;
  ssc_mode_t   mode;
  logic [15:0] exp_q[$];
  int          num_errors = 0, n_checks = 0, seed = 82347, i;
  int          n_stb = 0, n_led = 0;
  logic        led_q = 0;
  always #12.5 clk = ~clk;
  ssc_far_model FAR (.clk(clk), .rstn(rstn), .level(level), .fire(fire), .run(run),
    .pin_zero(p0), .pin_one(p1), .adc_value(adc));
  ssc_sample_sequencer_control DUT (.clk(clk), .rstn(rstn), .sync_reset(sync_reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .general_pin_zero(p0),
    .general_pin_one(p1), .adc_value(adc), .led_drive(led), .adc_strobe(stb), .slot_a_active(sa),
    .slot_b_active(sb), .channel_connect(conn), .mode(mode), .data_ready(dr));
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk1(input string nm, input logic s);
    chk16(nm, 16'h0001, {15'h0, s});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic idle(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge clk);
      if (led !== 1'b0 || sa !== 1'b0 || sb !== 1'b0) k++;
    end
    chk16("idle_activity", 16'h0000, 16'(k));
  endtask
  task automatic wait_dr(input int b);
    for (i = 0; i < 30000 && dr[b] !== 1'b1; i++) @(negedge clk);
    chk1("data_ready", dr[b]);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Read results and routing seen at the outputs
  always @(posedge clk) begin
    if (rd_seen) chk16("rd_data", exp_q.pop_front(), rd_data);
    rd_seen <= rd_en;
    a_q <= sa;
    b_q <= sb;
    led_q <= led;
    if (stb === 1'b1) n_stb <= n_stb + 1;
    if (led === 1'b1 && led_q !== 1'b1) n_led <= n_led + 1;
  end
  always @(negedge clk) begin
    if (a_q) chk16("connect_a", 16'h00C3, conn);
    if (b_q) chk16("connect_b", 16'h2184, conn);
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
  initial begin
    level <= 14'($random(seed)) & 14'h0FFF;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h10, 16'h0000);
    rd(8'h12, 16'h0020);
    rd(8'h7F, 16'h0000);
    wr(8'h10, 16'h0001);
    wr(8'h14, 16'h0510);
    wr(8'h12, 16'h0001);
    wr(8'h31, 16'h0200);
    wr(8'h36, 16'h0100);
    wr(8'h15, 16'h0001);
    rd(8'h14, 16'h0510);
    rd(8'h10, 16'h0001);
    wr(8'h10, 16'h0002);
    wait_dr(1);
    chk16("adc_strobe_count", 16'h0003, 16'(n_stb));
    chk16("led_pulse_count", 16'h0003, 16'(n_led));
    chk16("mode_out", 16'h0002, 16'(mode));
    rd(8'h66, {2'h0, level});
    wait_dr(0);
    chk16("adc_strobe_count", 16'h0005, 16'(n_stb));
    chk16("led_pulse_count", 16'h0005, 16'(n_led));
    rd(8'h64, {level, 2'h0});
    rd(8'h65, 16'h0000);
    @(posedge clk) sync_reset <= 1'b1;
    @(posedge clk) sync_reset <= 1'b0;
    rd(8'h10, 16'h0000);
    chk16("mode_out", 16'h0000, 16'(mode));
    idle(5000);
    rd(8'h14, 16'h0510);
    wr(8'h10, 16'h0001);
    wr(8'h12, 16'hFFFF);
    wr(8'h4F, 16'h0006);
    wr(8'h38, 16'h4000);
    wr(8'h10, 16'h0002);
    idle(5000);
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    for (i = 0; i < 4000 && sa !== 1'b1; i++) @(negedge clk);
    chk1("sync_delay", i >= 1100 && i <= 2500);
    wr(8'h10, 16'h0001);
    wr(8'h4F, 16'h0020);
    wr(8'h4B, 16'h0100);
    wr(8'h12, 16'h0001);
    wr(8'h10, 16'h0002);
    idle(5000);
    @(posedge clk) run <= 1'b1;
    for (i = 0; i < 5000 && sa !== 1'b1; i++) @(negedge clk);
    chk1("ext_clock_start", sa);
    print_verdict;
  end
endmodule // ssc_sample_sequencer_control_tb
